// ---- bench/pmsm_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host pins plus sequencer answers facing the state machine
module pmsm_host_model (
    input wire logic mclk, // Clock
    input wire logic hostOn, // Host asks for power
    input wire logic edgeMode, // Edge power-on option
    input wire logic selfTestStart, // Self-test running
    input wire logic powerUpStart, // Power up running
    input wire logic seqFail, // Make power up fail
    output logic powerOnPin, // Power-on pin
    output logic selfTestDone, // Self-test finished
    output logic procResetReleased, // Processor reset released
    output logic powerUpFail // Power up failure
);
    logic [2:0] stepCnt_r;

    // ----------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------
    // drive power-on pin
    assign powerOnPin = edgeMode ? ~hostOn : hostOn;

    // Answers come a few cycles late, as a slow sequencer would
    always_ff @(posedge mclk) begin
        if (selfTestStart || powerUpStart) begin
            stepCnt_r <= stepCnt_r + 3'h1;
        end else begin
            stepCnt_r <= 3'h0;
        end
    end
    assign selfTestDone = selfTestStart && stepCnt_r == 3'h3;
    assign procResetReleased = powerUpStart && !seqFail && stepCnt_r == 3'h4;
    assign powerUpFail = powerUpStart && seqFail && stepCnt_r == 3'h2;
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pmsm_pkg::*;
    logic mclk = 0, rst_n = 0, hostOn = 0, edgeMode = 0, lpPin = 0;
    logic tmPin = 0, failIn = 1, pol = 0, offMode = 0, failEn = 0;
    logic tOk = 1, wdEv = 0, seqFail = 0;
    logic uvOk = 1, trimErr = 0, cfgErr = 0, stErr = 0;
    localparam int WD_CYC = 10; // Short watchdog hold for the bench
    logic [3:0] limit = 4'h2;
    logic pinOn, stDone, rstRel, puFail, stStart, puStart, sysOn;
    pmsm_state_e stateOut;
    logic [3:0] cnt;
    int mismatches = 0, total_checks = 0, n, i;

    // Clock, 25 ns period
    always #12.5 mclk = ~mclk;

    pmsm_power_state_machine #(.SAFETY_VARIANT(1'b1),
        .WD_DELAY_CYCLES(WD_CYC)) DUT (.mclk(mclk), .rst_n(rst_n),
        .powerOnPin(pinOn), .lowPowerPin(lpPin), .testModePin(tmPin),
        .externalFailInput(failIn), .lowPowerPinPolarityBit(pol),
        .offModeSelectBit(offMode), .powerOnEdgeSelect(edgeMode),
        .externalFailEnable(failEn), .vinAboveUv(uvOk),
        .vinBelowOvlo(1'b1), .ovloDisable(1'b0), .tempBelowTsd(tOk),
        .trimLoadErrorFlag(trimErr), .configLoadErrorFlag(cfgErr),
        .selfTestDone(stDone), .selfTestErrorFlag(stErr),
        .hardWdEvent(wdEv), .watchdogEventLimit(limit),
        .procResetReleased(rstRel), .powerUpFail(puFail),
        .stateOut(stateOut), .watchdogEventCounter(cnt),
        .selfTestStart(stStart), .powerUpStart(puStart),
        .systemOn(sysOn));

    pmsm_host_model host (.mclk(mclk), .hostOn(hostOn),
        .edgeMode(edgeMode), .selfTestStart(stStart),
        .powerUpStart(puStart), .seqFail(seqFail), .powerOnPin(pinOn),
        .selfTestDone(stDone), .procResetReleased(rstRel),
        .powerUpFail(puFail));

    // ----------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------
    task automatic check_val(input logic [3:0] got, input logic [3:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Poll on the falling edge, bounded
    task automatic wait_state(input pmsm_state_e exp, input int lim);
        n = 0;
        @(negedge mclk);
        while (stateOut !== exp && n < lim) begin
            @(negedge mclk);
            n++;
        end
        check_val(stateOut, exp);
    endtask

    task automatic do_reset();
        @(posedge mclk) rst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask

    task automatic wd_pulse();
        @(posedge mclk) wdEv <= 1'b1;
        @(posedge mclk) wdEv <= 1'b0;
    endtask

    task automatic summarize();
        $display("Checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (3000) @(posedge mclk);
        mismatches++;
        $display("Error at %0t: timeout got %h exp %h", $time, 0, 1);
        summarize();
    end

    // ----------------------------------------------------------
    // Tests
    // ----------------------------------------------------------
    initial begin
        do_reset();
        wait_state(ST_LOW_POWER_OFF_STATE, 0);
        @(posedge mclk) hostOn <= 1'b1;
        wait_state(ST_SELF_TEST, 8);
        wait_state(ST_QPU_WAIT, 10);
        wait_state(ST_PWR_UP, 3);
        wait_state(ST_RUN, 10);
        check_val({3'h0, sysOn}, 4'h1);
        $display("Test level power-on done");
        // Standby follows pin xor polarity
        for (i = 0; i < 4; i++) begin
            @(posedge mclk);
            pol <= i[1];
            lpPin <= i[0] ~^ i[1];
            wait_state(i[0] ? ST_RUN : ST_STANDBY, 8);
        end
        $display("Test standby polarity done");
        wd_pulse();
        wait_state(ST_WD_RESET, 4);
        wait_state(ST_RUN, 30);
        check_val({3'h0, n == WD_CYC - 1}, 4'h1);
        check_val(cnt, 4'h1);
        wd_pulse();
        wait_state(ST_FAULT_DOWN, 30);
        check_val(cnt, 4'h2);
        $display("Test watchdog done");
        @(posedge mclk);
        hostOn <= 1'b0;
        edgeMode <= 1'b1;
        tOk <= 1'b0;
        do_reset();
        @(posedge mclk) hostOn <= 1'b1;
        repeat (8) @(posedge mclk);
        wait_state(ST_LOW_POWER_OFF_STATE, 0);
        @(posedge mclk) hostOn <= 1'b0;
        tOk <= 1'b1;
        repeat (4) @(posedge mclk);
        hostOn <= 1'b1;
        wait_state(ST_SELF_TEST, 8);
        wait_state(ST_RUN, 30);
        $display("Test edge power-on done");
        @(posedge mclk);
        hostOn <= 1'b0;
        edgeMode <= 1'b0;
        offMode <= 1'b1;
        failEn <= 1'b1;
        failIn <= 1'b0;
        seqFail <= 1'b1;
        do_reset();
        wait_state(ST_QPU_WAIT, 20);
        repeat (6) @(posedge mclk);
        wait_state(ST_QPU_WAIT, 0);
        @(posedge mclk) hostOn <= 1'b1;
        repeat (8) @(posedge mclk);
        wait_state(ST_QPU_WAIT, 0);
        // Each pass leaves one blocker set, so the wait must hold
        for (i = 0; i < 4; i++) begin
            @(posedge mclk);
            failIn <= 1'b1;
            stErr <= (i == 0);
            uvOk <= (i != 1);
            trimErr <= (i == 2);
            cfgErr <= (i == 3);
            repeat (8) @(posedge mclk);
            wait_state(ST_QPU_WAIT, 0);
        end
        @(posedge mclk) cfgErr <= 1'b0;
        wait_state(ST_PWR_UP, 8);
        wait_state(ST_FAULT_DOWN, 10);
        $display("Test off-mode wait done");
        @(posedge mclk);
        hostOn <= 1'b0;
        offMode <= 1'b0;
        failEn <= 1'b0;
        seqFail <= 1'b0;
        tmPin <= 1'b1;
        do_reset();
        wait_state(ST_SELF_TEST, 8);
        wait_state(ST_QPU_WAIT, 10);
        repeat (6) @(posedge mclk);
        wait_state(ST_QPU_WAIT, 0);
        @(posedge mclk) hostOn <= 1'b1;
        wait_state(ST_PWR_UP, 8);
        $display("Test test-mode done");
        summarize();
    end
endmodule
`default_nettype wire

// ---- core/pmsm_pkg.sv ----
package pmsm_pkg;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 40_000_000;
    localparam int WD_DELAY_NS = 30_000;  // Watchdog reset hold, 30 us
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
    // Least time, rounded up
    localparam int WD_DELAY_CYC =
        (WD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WD_TMR_W = 11;
    localparam int WD_CNT_W = 4;

    // ---------------------------------------------------------------
    // States, Gray coded along off -> test -> wait -> up -> on path
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_LOW_POWER_OFF_STATE = 4'h0,
        ST_SELF_TEST = 4'h1,
        ST_QPU_WAIT = 4'h3,
        ST_PWR_UP = 4'h2,
        ST_RUN = 4'h6,
        ST_STANDBY = 4'h7,
        ST_WD_RESET = 4'h5,
        ST_FAULT_DOWN = 4'h4
    } pmsm_state_e;
endpackage

// ---- core/pmsm_power_state_machine.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// - Standby to run when pin level, after polarity bit, reads run.
// - Run to standby when pin level, after polarity bit, reads standby.
// - Hard watchdog reset event while on forces watchdog reset state.
// - Back to on after 30 us if event counter below limit.
// - Counter equal to limit sends watchdog reset to fault power-down.
// - Leaving off goes via self-test on safety variant, else to wait.
// - Level option: high power-on pin with clear load errors leaves off.
// - Edge option: power-on high-to-low edge is the power-up event.
// - Power-up also needs supply in window and temperature below limit.
// - Test-mode pin high passes off to wait regardless of events.
// - Self-test to wait on pass, or when test-mode pin is high.
// - Off-mode 0 power-on: wait is transitory into power up.
// - Off-mode 1 or test mode: wait holds until a power-on event.
// - External fail enable requires external fail input high to start.
// - Power-up ends in on once processor reset is released.
// - Failure during power-up goes to fault power-down.
module pmsm_power_state_machine #(
    parameter bit SAFETY_VARIANT = 1'b1,
    parameter int WD_DELAY_CYCLES = pmsm_pkg::WD_DELAY_CYC
) (
    input wire logic mclk, // 40 MHz clock
    input wire logic rst_n, // Async reset, active low
    input wire logic powerOnPin, // Power-on pin
    input wire logic lowPowerPin, // Low-power request pin
    input wire logic testModePin, // Test-mode pin
    input wire logic externalFailInput, // External fail, high is ok
    input wire logic lowPowerPinPolarityBit, // Inverts low-power pin
    input wire logic offModeSelectBit, // Off-mode select
    input wire logic powerOnEdgeSelect, // 0 level, 1 falling edge
    input wire logic externalFailEnable, // Use external fail input
    input wire logic vinAboveUv, // Supply above undervoltage
    input wire logic vinBelowOvlo, // Supply below overvoltage
    input wire logic ovloDisable, // Overvoltage lockout disabled
    input wire logic tempBelowTsd, // Junction below shutdown
    input wire logic trimLoadErrorFlag, // Trim load error
    input wire logic configLoadErrorFlag, // Config load error
    input wire logic selfTestDone, // Self-test finished pulse
    input wire logic selfTestErrorFlag, // Self-test error
    input wire logic hardWdEvent, // Hard watchdog reset pulse
    input wire logic [pmsm_pkg::WD_CNT_W-1:0] watchdogEventLimit, // Limit
    input wire logic procResetReleased, // Sequencer released reset
    input wire logic powerUpFail, // Failure during power up
    output pmsm_pkg::pmsm_state_e stateOut, // Current state
    output logic [pmsm_pkg::WD_CNT_W-1:0] watchdogEventCounter, // Count
    output logic selfTestStart, // In self-test
    output logic powerUpStart, // In power up
    output logic systemOn // In run or standby
);
    import pmsm_pkg::*;

    // ---------------------------------------------------------------
    // Reset release
    // ---------------------------------------------------------------
    logic rstMeta_r, rstSyncN;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_r <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSyncN <= rstMeta_r;
        end
    end

    // ---------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ---------------------------------------------------------------
    logic [3:0] pinSync;
    logic pwrOnS, lowPwrS, testS, xFailS, pwrOnPrev_r;
    pmsm_sync #(.WIDTH(4)) uSync (
        .mclk(mclk),
        .rstSyncN(rstSyncN),
        .asyncIn({powerOnPin, lowPowerPin, testModePin, externalFailInput}),
        .syncOut(pinSync)
    );
    assign {pwrOnS, lowPwrS, testS, xFailS} = pinSync;

    // Previous synchronised power-on sample
    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pwrOnPrev_r <= 1'b0;
        end else begin
            pwrOnPrev_r <= pwrOnS;
        end
    end

    // ---------------------------------------------------------------
    // Conditions
    // ---------------------------------------------------------------
    logic pwrOnEvt, envOk, loadOk, xfOk, standbyReq;
    assign pwrOnEvt = powerOnEdgeSelect ? (pwrOnPrev_r && !pwrOnS) : pwrOnS;
    assign envOk = vinAboveUv && (vinBelowOvlo || ovloDisable) && tempBelowTsd;
    assign loadOk = !trimLoadErrorFlag && !configLoadErrorFlag;
    assign xfOk = !externalFailEnable || xFailS;
    assign standbyReq = lowPwrS ^ lowPowerPinPolarityBit;

    // ---------------------------------------------------------------
    // State machine
    // ---------------------------------------------------------------
    pmsm_state_e state_r, state_nxt;
    logic direct_r, direct_nxt;
    logic [WD_TMR_W-1:0] wdTmr_r;
    logic wdDone;
    localparam logic [WD_TMR_W-1:0] WD_LAST =
        WD_TMR_W'(WD_DELAY_CYCLES - 1);
    assign wdDone = (wdTmr_r == WD_LAST);

    // Next state
    always_comb begin
        state_nxt = state_r;
        direct_nxt = direct_r;
        case (state_r)
            ST_LOW_POWER_OFF_STATE: begin
                if (testS || offModeSelectBit ||
                    (pwrOnEvt && envOk && loadOk)) begin
                    direct_nxt = !testS && !offModeSelectBit;
                    state_nxt = SAFETY_VARIANT ? ST_SELF_TEST : ST_QPU_WAIT;
                end
            end
            ST_SELF_TEST: begin
                if (testS || (selfTestDone && !selfTestErrorFlag)) begin
                    state_nxt = ST_QPU_WAIT;
                end
            end
            ST_QPU_WAIT: begin
                if (loadOk && !selfTestErrorFlag && xfOk) begin
                    if (direct_r && !testS) begin
                        state_nxt = ST_PWR_UP;
                    end else if (pwrOnEvt && envOk) begin
                        state_nxt = ST_PWR_UP;
                    end
                end
            end
            ST_PWR_UP: begin
                if (powerUpFail) begin
                    state_nxt = ST_FAULT_DOWN;
                end else if (procResetReleased) begin
                    state_nxt = standbyReq ? ST_STANDBY : ST_RUN;
                end
            end
            ST_RUN, ST_STANDBY: begin
                if (hardWdEvent) begin
                    state_nxt = ST_WD_RESET;
                end else if (state_r == ST_RUN && standbyReq) begin
                    state_nxt = ST_STANDBY;
                end else if (state_r == ST_STANDBY && !standbyReq) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_WD_RESET: begin
                if (watchdogEventCounter == watchdogEventLimit) begin
                    state_nxt = ST_FAULT_DOWN;
                end else if (wdDone &&
                             watchdogEventCounter < watchdogEventLimit) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_FAULT_DOWN: state_nxt = ST_FAULT_DOWN;
            default: state_nxt = ST_LOW_POWER_OFF_STATE;
        endcase
    end

    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state_r <= ST_LOW_POWER_OFF_STATE;
            direct_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            direct_r <= direct_nxt;
        end
    end

    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            wdTmr_r <= '0;
        end else if (state_r != ST_WD_RESET) begin
            wdTmr_r <= '0;
        end else if (!wdDone) begin
            wdTmr_r <= wdTmr_r + 1'b1;
        end
    end

    // Watchdog event counter, counts entries into watchdog reset
    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            watchdogEventCounter <= '0;
        end else if (state_r == ST_LOW_POWER_OFF_STATE) begin
            watchdogEventCounter <= '0;
        end else if (state_nxt == ST_WD_RESET && state_r != ST_WD_RESET &&
                     watchdogEventCounter != '1) begin
            watchdogEventCounter <= watchdogEventCounter + 1'b1;
        end
    end

    // Outputs
    assign stateOut = state_r;
    assign selfTestStart = (state_r == ST_SELF_TEST);
    assign powerUpStart = (state_r == ST_PWR_UP);
    assign systemOn = (state_r == ST_RUN) || (state_r == ST_STANDBY);

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstSyncN);

    run_to_stby_a: assert property (
        state_r == ST_RUN && !hardWdEvent && standbyReq
        |=> state_r == ST_STANDBY)
        else $error("run did not enter standby");
    stby_to_run_a: assert property (
        state_r == ST_STANDBY && !hardWdEvent && !standbyReq
        |=> state_r == ST_RUN)
        else $error("standby did not enter run");
    wd_entry_a: assert property (
        systemOn && hardWdEvent |=> state_r == ST_WD_RESET)
        else $error("watchdog event ignored");
    wd_hold_a: assert property (
        state_r == ST_WD_RESET && $past(state_r) != ST_WD_RESET
        && watchdogEventCounter < watchdogEventLimit
        |-> state_r == ST_WD_RESET [*8])
        else $error("watchdog reset left too early");
    wd_limit_a: assert property (
        state_r == ST_WD_RESET && watchdogEventCounter == watchdogEventLimit
        |=> state_r == ST_FAULT_DOWN)
        else $error("watchdog limit not honoured");
    off_exit_a: assert property (
        state_r == ST_LOW_POWER_OFF_STATE && state_nxt != ST_LOW_POWER_OFF_STATE
        |=> state_r == (SAFETY_VARIANT ? ST_SELF_TEST : ST_QPU_WAIT))
        else $error("wrong state after off");
    test_exit_a: assert property (
        state_r == ST_SELF_TEST && testS |=> state_r == ST_QPU_WAIT)
        else $error("test mode did not leave self-test");
    xfail_gate_a: assert property (
        state_r == ST_QPU_WAIT && externalFailEnable && !xFailS
        |=> state_r == ST_QPU_WAIT)
        else $error("power up despite external fail");
    pu_fail_a: assert property (
        state_r == ST_PWR_UP && powerUpFail |=> state_r == ST_FAULT_DOWN)
        else $error("power up failure not handled");

    reach_on_c: cover property (state_r == ST_PWR_UP ##1 systemOn);
    wd_back_c: cover property (state_r == ST_WD_RESET ##1 state_r == ST_RUN);
    stby_c: cover property (state_r == ST_STANDBY);
endmodule
`default_nettype wire

// ---- core/pmsm_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------------------------
// Two-stage synchroniser per bit
// -------------------------------------------------------------------
module pmsm_sync #(
    parameter int WIDTH = 4
) (
    input wire logic mclk, // Clock
    input wire logic rstSyncN, // Reset, active low
    input wire logic [WIDTH-1:0] asyncIn, // Raw pins
    output logic [WIDTH-1:0] syncOut // Synchronised pins
);
    logic [WIDTH-1:0] stage1_r;

    // Both stages clear on reset
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge mclk or negedge rstSyncN) begin
                if (!rstSyncN) begin
                    stage1_r[i] <= 1'b0;
                    syncOut[i] <= 1'b0;
                end else begin
                    stage1_r[i] <= asyncIn[i];
                    syncOut[i] <= stage1_r[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire
